// >>> hdl/otrim_top.sv
// Dual-channel digital offset trim and auxiliary trim converter code store.
// Assumes the serial configuration port decoder presents byte writes and reads
// on the internal digital clock, and that samples arrive after modulation.
//
// Functional notes
// (RULE_01) Offset is the last digital step; result goes straight to the converter core.
// (RULE_02) Two independent 12-bit settings, channel A and channel B, each own stream.
// (RULE_03) Setting is two's complement; twice its value is added; zero adds nothing.
// (RULE_04) Two auxiliary trim converters, each with its own stored 10-bit code.
// (RULE_05) Auxiliary code is straight binary; 0 complementary, 1023 true, 512 equal.
// (RULE_06) Sums beyond the 14-bit range clamp to the nearest full-scale code.
`timescale 1ns/10ps
`default_nettype none
module otrim_top
	import otrim_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic [DATA_W-1:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [DATA_W-1:0] REG_RDATA_O,
	input wire logic [SAMPLE_W-1:0] SAMPLE_A_I,
	input wire logic [SAMPLE_W-1:0] SAMPLE_B_I,
	input wire logic SAMPLE_VALID_I,
	output logic [SAMPLE_W-1:0] CORE_A_O,
	output logic [SAMPLE_W-1:0] CORE_B_O,
	output logic CORE_VALID_O,
	output logic [AUX_W-1:0] AUX_A_CODE_O,
	output logic [AUX_W-1:0] AUX_B_CODE_O,
	output logic [GAIN_COARSE_W-1:0] GAIN_COARSE_A_O,
	output logic [GAIN_COARSE_W-1:0] GAIN_COARSE_B_O
);

	// Configuration storage.
	logic [DATA_W-1:0] a_first_ff;
	logic [DATA_W-1:0] a_third_ff;
	logic [DATA_W-1:0] b_first_ff;
	logic [DATA_W-1:0] b_third_ff;
	logic [AUX_W-1:0] aux_a_ff;
	logic [AUX_W-1:0] aux_b_ff;
	logic [NUM_CHAN-1:0] clamp_sticky_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic [NUM_CHAN-1:0] nxt_clamp_sticky;

	// Per-lane views gathered so the generate loop can index them.
	logic [OFFSET_W-1:0] chan_offset [NUM_CHAN];
	logic [SAMPLE_W-1:0] chan_sample [NUM_CHAN];
	logic [SAMPLE_W-1:0] chan_result [NUM_CHAN];
	logic [NUM_CHAN-1:0] chan_valid;
	logic [NUM_CHAN-1:0] chan_clamped;

	// Each setting is split over a low byte and the high nibble of the third register.
	assign chan_offset[0] = {a_third_ff[OFS_HIGH_LSB +: 4], a_first_ff}; // RULE_02
	assign chan_offset[1] = {b_third_ff[OFS_HIGH_LSB +: 4], b_first_ff}; // RULE_02
	assign chan_sample[0] = SAMPLE_A_I;
	assign chan_sample[1] = SAMPLE_B_I;

	// Channel A configuration writes.
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			a_first_ff <= RST_CONFIG_FIRST;
			a_third_ff <= RST_CONFIG_THIRD;
		end else if (REG_WR_I) begin
			if (REG_ADDR_I == ADDR_CHAN_A_CONFIG_FIRST) begin
				a_first_ff <= REG_WDATA_I;
			end
			if (REG_ADDR_I == ADDR_CHAN_A_CONFIG_THIRD) begin
				a_third_ff <= REG_WDATA_I;
			end
		end
	end

	// Channel B configuration writes, kept apart so a write never touches the other lane.
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			b_first_ff <= RST_CONFIG_FIRST;
			b_third_ff <= RST_CONFIG_THIRD;
		end else if (REG_WR_I) begin
			if (REG_ADDR_I == ADDR_CHAN_B_CONFIG_FIRST) begin
				b_first_ff <= REG_WDATA_I;
			end
			if (REG_ADDR_I == ADDR_CHAN_B_CONFIG_THIRD) begin
				b_third_ff <= REG_WDATA_I;
			end
		end
	end

	// Auxiliary codes are written as a low byte and a two-bit high part.
	// A split write changes the output between the two bytes; software
	// should write the high part last when a glitch matters.
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			aux_a_ff <= RST_AUX_CODE;
			aux_b_ff <= RST_AUX_CODE;
		end else if (REG_WR_I) begin
			unique case (REG_ADDR_I)
				ADDR_AUX_A_LOW: begin
					aux_a_ff[7:0] <= REG_WDATA_I; // RULE_04
				end
				ADDR_AUX_A_HIGH: begin
					aux_a_ff[AUX_W-1:8] <= REG_WDATA_I[1:0]; // RULE_04
				end
				ADDR_AUX_B_LOW: begin
					aux_b_ff[7:0] <= REG_WDATA_I; // RULE_04
				end
				ADDR_AUX_B_HIGH: begin
					aux_b_ff[AUX_W-1:8] <= REG_WDATA_I[1:0]; // RULE_04
				end
				default: begin
				end
			endcase
		end
	end

	// Clamp events are sticky; a write of one clears a bit, but a new event
	// in the same cycle wins so that no clamp goes unseen.
	always_comb begin
		nxt_clamp_sticky = clamp_sticky_ff;
		if (REG_WR_I && (REG_ADDR_I == ADDR_CLAMP_STATUS)) begin
			nxt_clamp_sticky = clamp_sticky_ff & ~REG_WDATA_I[NUM_CHAN-1:0];
		end
		nxt_clamp_sticky = nxt_clamp_sticky | chan_clamped;
	end

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			clamp_sticky_ff <= '0;
		end else begin
			clamp_sticky_ff <= nxt_clamp_sticky;
		end
	end

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		nxt_rdata = RST_RDATA;
		unique case (REG_ADDR_I)
			ADDR_CHAN_A_CONFIG_FIRST: begin
				nxt_rdata = a_first_ff;
			end
			ADDR_CHAN_A_CONFIG_THIRD: begin
				nxt_rdata = a_third_ff;
			end
			ADDR_CHAN_B_CONFIG_FIRST: begin
				nxt_rdata = b_first_ff;
			end
			ADDR_CHAN_B_CONFIG_THIRD: begin
				nxt_rdata = b_third_ff;
			end
			ADDR_AUX_A_LOW: begin
				nxt_rdata = aux_a_ff[7:0];
			end
			ADDR_AUX_A_HIGH: begin
				nxt_rdata = {6'h00, aux_a_ff[AUX_W-1:8]};
			end
			ADDR_AUX_B_LOW: begin
				nxt_rdata = aux_b_ff[7:0];
			end
			ADDR_AUX_B_HIGH: begin
				nxt_rdata = {6'h00, aux_b_ff[AUX_W-1:8]};
			end
			ADDR_CLAMP_STATUS: begin
				nxt_rdata = {6'h00, clamp_sticky_ff};
			end
			default: begin
				nxt_rdata = RST_RDATA;
			end
		endcase
	end

	// Read data is registered so the port sees a clean value one cycle later.
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			rdata_ff <= RST_RDATA;
		end else if (REG_RD_I) begin
			rdata_ff <= nxt_rdata;
		end
	end

	// One adder per channel; each lane sees only its own setting.
	generate
		for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_lane
			otrim_lane_if lane ();

			assign lane.sample = chan_sample[ch];
			assign lane.sample_valid = SAMPLE_VALID_I;
			assign lane.offset = chan_offset[ch]; // RULE_02
			assign chan_result[ch] = lane.result;
			assign chan_valid[ch] = lane.result_valid;
			assign chan_clamped[ch] = lane.clamped;

			otrim_adder u_adder (
				.clk_i(REF_CLK_I),
				.rst_i(SYS_RST_I),
				.lane(lane)
			);
		end
	endgenerate

	// The trimmed samples leave with nothing after them but the converter core.
	assign CORE_A_O = chan_result[0]; // RULE_01
	assign CORE_B_O = chan_result[1]; // RULE_01
	assign CORE_VALID_O = &chan_valid; // Both lanes share one valid, so their flags agree.

	// Auxiliary codes go out as plain binary; the analog cell splits its
	// current in proportion, so no encoding is applied here.
	assign AUX_A_CODE_O = aux_a_ff; // RULE_05
	assign AUX_B_CODE_O = aux_b_ff; // RULE_05
	assign GAIN_COARSE_A_O = a_third_ff[GAIN_COARSE_LSB +: GAIN_COARSE_W];
	assign GAIN_COARSE_B_O = b_third_ff[GAIN_COARSE_LSB +: GAIN_COARSE_W];
	assign REG_RDATA_O = rdata_ff;
endmodule
`default_nettype wire

// >>> include/otrim_pkg.sv
// Constants and types shared by the dual-channel digital offset trim block.
// Assumes a byte-wide register port on the internal clock domain.
package otrim_pkg;

	// Datapath widths.
	localparam int SAMPLE_W = 14;
	localparam int OFFSET_W = 12;
	localparam int AUX_W = 10;
	localparam int ADDR_W = 5;
	localparam int DATA_W = 8;
	localparam int NUM_CHAN = 2;

	// Register offsets on the serial configuration port.
	localparam logic [ADDR_W-1:0] ADDR_CHAN_A_CONFIG_FIRST = 5'h09;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_A_CONFIG_THIRD = 5'h0b;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_B_CONFIG_FIRST = 5'h0c;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_B_CONFIG_THIRD = 5'h0e;
	localparam logic [ADDR_W-1:0] ADDR_AUX_A_LOW = 5'h10;
	localparam logic [ADDR_W-1:0] ADDR_AUX_A_HIGH = 5'h11;
	localparam logic [ADDR_W-1:0] ADDR_AUX_B_LOW = 5'h12;
	localparam logic [ADDR_W-1:0] ADDR_AUX_B_HIGH = 5'h13;
	localparam logic [ADDR_W-1:0] ADDR_CLAMP_STATUS = 5'h14;

	// Field positions: the offset high nibble and the coarse gain share the third register.
	localparam int OFS_HIGH_LSB = 4;
	localparam int GAIN_COARSE_LSB = 0;
	localparam int GAIN_COARSE_W = 4;

	// Values after reset.
	localparam logic [DATA_W-1:0] RST_CONFIG_FIRST = 8'h00;
	localparam logic [DATA_W-1:0] RST_CONFIG_THIRD = 8'h0d;
	localparam logic [AUX_W-1:0] RST_AUX_CODE = 10'h200;
	localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;

	// Full-scale limits of the converter core code, two's complement.
	localparam logic signed [SAMPLE_W-1:0] CODE_MAX = 14'sh1fff;
	localparam logic signed [SAMPLE_W-1:0] CODE_MIN = 14'sh2000;

endpackage

// >>> include/otrim_lane_if.sv
// Interface carrying one channel lane between the trim top and its adder.
// Assumes both ends sit on the same internal digital clock.
`timescale 1ns/10ps
`default_nettype none
interface otrim_lane_if;
	import otrim_pkg::*;

	logic [SAMPLE_W-1:0] sample;
	logic sample_valid;
	logic [OFFSET_W-1:0] offset;
	logic [SAMPLE_W-1:0] result;
	logic result_valid;
	logic clamped;

	modport top (output sample, output sample_valid, output offset,
		input result, input result_valid, input clamped);
	modport adder (input sample, input sample_valid, input offset,
		output result, output result_valid, output clamped);
endinterface
`default_nettype wire

// >>> hdl/otrim_adder.sv
// One channel of offset trim: doubles the setting, adds it, clamps to full scale.
// Assumes the setting is stable or changes on a clean sample boundary.
`timescale 1ns/10ps
`default_nettype none
module otrim_adder
	import otrim_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_i,
	otrim_lane_if.adder lane
);

	logic signed [SAMPLE_W+1:0] nxt_sum;
	logic [SAMPLE_W-1:0] result_ff;
	logic valid_ff;
	logic clamped_ff;

	// Offset doubled by a left shift; both operands sign-extended to keep the carry.
	always_comb begin
		nxt_sum = '0;
		nxt_sum = {{2{lane.sample[SAMPLE_W-1]}}, lane.sample}
			+ {{(SAMPLE_W+1-OFFSET_W){lane.offset[OFFSET_W-1]}}, lane.offset, 1'b0}; // RULE_03
	end

	// Saturate rather than wrap, since a wrapped code swings the output rail to rail.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_ff <= '0;
			clamped_ff <= 1'b0;
		end else if (lane.sample_valid) begin
			if (nxt_sum > $signed({{2{CODE_MAX[SAMPLE_W-1]}}, CODE_MAX})) begin
				result_ff <= CODE_MAX; // RULE_06
				clamped_ff <= 1'b1;
			end else if (nxt_sum < $signed({{2{CODE_MIN[SAMPLE_W-1]}}, CODE_MIN})) begin
				result_ff <= CODE_MIN; // RULE_06
				clamped_ff <= 1'b1;
			end else begin
				result_ff <= nxt_sum[SAMPLE_W-1:0];
				clamped_ff <= 1'b0;
			end
		end else begin
			clamped_ff <= 1'b0;
		end
	end

	// The valid flag follows the sample through the single stage.
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_ff <= 1'b0;
		end else begin
			valid_ff <= lane.sample_valid;
		end
	end

	assign lane.result = result_ff;
	assign lane.result_valid = valid_ff;
	assign lane.clamped = clamped_ff;
endmodule
`default_nettype wire

// >>> bench/otrim_monitor.sv
// Concurrent checks on the trim top: sample latency, hold, clamp, parity, aux codes.
// Assumes it is bound to every instance of the top module.
`timescale 1ns/10ps
`default_nettype none
module otrim_monitor
	import otrim_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	input wire logic REG_WR_I,
	input wire logic [SAMPLE_W-1:0] SAMPLE_A_I,
	input wire logic [SAMPLE_W-1:0] SAMPLE_B_I,
	input wire logic SAMPLE_VALID_I,
	input wire logic [SAMPLE_W-1:0] CORE_A_O,
	input wire logic [SAMPLE_W-1:0] CORE_B_O,
	input wire logic CORE_VALID_O,
	input wire logic [AUX_W-1:0] AUX_A_CODE_O,
	input wire logic [AUX_W-1:0] AUX_B_CODE_O
);
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// A taken sample reaches the core exactly one cycle later.
	sequence s_take;
		SAMPLE_VALID_I ##1 CORE_VALID_O;
	endsequence
	property p_lat;
		SAMPLE_VALID_I |-> s_take;
	endproperty
	property p_hold;
		!SAMPLE_VALID_I |=> $stable(CORE_A_O) && $stable(CORE_B_O);
	endproperty
	// A full-scale high on A and a full-scale low on B must never wrap; a small offset keeps their sign.
	property p_sat_hi;
		SAMPLE_VALID_I && SAMPLE_A_I == CODE_MAX |=> !CORE_A_O[13];
	endproperty
	property p_sat_lo;
		SAMPLE_VALID_I && SAMPLE_B_I == CODE_MIN |=> CORE_B_O[13];
	endproperty
	// An even offset on a sample that cannot clamp leaves the low bit alone.
	property p_par_a;
		SAMPLE_VALID_I && SAMPLE_A_I[13] == SAMPLE_A_I[12] |=> CORE_A_O[0] == $past(SAMPLE_A_I[0]);
	endproperty
	property p_par_b;
		SAMPLE_VALID_I && SAMPLE_B_I[13] == SAMPLE_B_I[12] |=> CORE_B_O[0] == $past(SAMPLE_B_I[0]);
	endproperty
	property p_aux;
		!REG_WR_I |=> $stable(AUX_A_CODE_O) && $stable(AUX_B_CODE_O);
	endproperty
	a_lat: assert property (p_lat) else $error("core valid late");
	a_hold: assert property (p_hold) else $error("core moved idle");
	a_sat_hi: assert property (p_sat_hi) else $error("high wrap");
	a_sat_lo: assert property (p_sat_lo) else $error("low wrap");
	a_par_a: assert property (p_par_a) else $error("odd step A");
	a_par_b: assert property (p_par_b) else $error("odd step B");
	a_aux: assert property (p_aux) else $error("aux moved");
endmodule
bind otrim_top otrim_monitor otrim_monitor_i (.REF_CLK_I, .SYS_RST_I, .REG_WR_I, .SAMPLE_A_I,
	.SAMPLE_B_I, .SAMPLE_VALID_I, .CORE_A_O, .CORE_B_O, .CORE_VALID_O, .AUX_A_CODE_O,
	.AUX_B_CODE_O);
`default_nettype wire

// >>> bench/test_otrim_top.sv
// Self-checking bench for the trim top: register port, sample path, aux codes.
// Assumes the design and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_otrim_top
	import otrim_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, vld = 1'b0, cv, rd_d = 1'b0;
	logic [ADDR_W-1:0] addr = 5'h00;
	logic [DATA_W-1:0] wdata = 8'h00, rdata;
	logic [SAMPLE_W-1:0] sa = 14'h0000, sb = 14'h0000, ca, cb;
	logic [AUX_W-1:0] auxa, auxb;
	logic [GAIN_COARSE_W-1:0] ga, gb;
	logic [OFFSET_W-1:0] ofs [2] = '{12'h000, 12'h000};
	logic [OFFSET_W-1:0] tbl [7] = '{12'h800, 12'h801, 12'hfff, 12'h000, 12'h001, 12'h7fe, 12'h7ff};
	logic [AUX_W-1:0] aux [3] = '{10'h000, 10'h3ff, 10'h200};
	logic [DATA_W-1:0] rq [$];
	logic [2*SAMPLE_W-1:0] cq [$];
	int num_errors = 0, comparisons = 0, cycles = 0, seed = 21;

	otrim_top otrim_top_i (.REF_CLK_I(clk), .SYS_RST_I(rst), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
		.SAMPLE_A_I(sa), .SAMPLE_B_I(sb), .SAMPLE_VALID_I(vld), .CORE_A_O(ca), .CORE_B_O(cb),
		.CORE_VALID_O(cv), .AUX_A_CODE_O(auxa), .AUX_B_CODE_O(auxb),
		.GAIN_COARSE_A_O(ga), .GAIN_COARSE_B_O(gb));

	// Free-running 50 MHz clock.
	initial forever #10 clk = ~clk;

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	// One compare per kind of result, so a mismatch line is easy to place.
	task automatic cmp_read(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		cmp(got, exp);
	endtask

	task automatic cmp_core(input logic [2*SAMPLE_W-1:0] got, input logic [2*SAMPLE_W-1:0] exp);
		cmp(got, exp);
	endtask

	task automatic tally_and_finish();
		if (num_errors == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Saturating model, so full-scale inputs show whether the sum wraps.
	function automatic logic [SAMPLE_W-1:0] trim(input logic [SAMPLE_W-1:0] s,
		input logic [OFFSET_W-1:0] o);
		int r;
		r = int'($signed(s)) + 2 * int'($signed(o));
		r = r > 8191 ? 8191 : (r < -8192 ? -8192 : r);
		return r[SAMPLE_W-1:0];
	endfunction

	// Every strobe is assigned once per cycle, so requests may run back to back.
	task automatic put(input logic w, input logic r, input logic v,
		input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		wr <= w;
		rd <= r;
		vld <= v;
		addr <= a;
		wdata <= d;
		@(posedge clk);
	endtask

	task automatic setofs(input int ch, input logic [OFFSET_W-1:0] v, input logic [3:0] g);
		ofs[ch] = v;
		put(1'b1, 1'b0, 1'b0, ch ? ADDR_CHAN_B_CONFIG_FIRST : ADDR_CHAN_A_CONFIG_FIRST, v[7:0]);
		put(1'b1, 1'b0, 1'b0, ch ? ADDR_CHAN_B_CONFIG_THIRD : ADDR_CHAN_A_CONFIG_THIRD, {v[11:8], g});
	endtask

	task automatic rreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		rq.push_back(e);
		put(1'b0, 1'b1, 1'b0, a, 8'h00);
	endtask

	task automatic samp(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
		cq.push_back({trim(a, ofs[0]), trim(b, ofs[1])});
		sa <= a;
		sb <= b;
		put(1'b0, 1'b0, 1'b1, addr, wdata);
	endtask

	// Pairs every read and trimmed sample with its oldest note; also bounds the run.
	always @(posedge clk) begin
		cycles++;
		if (cycles > 2000) begin
			num_errors++;
			tally_and_finish();
		end
		if (rd_d)
			cmp_read(rdata, rq.pop_front());
		if (cv)
			cmp_core({ca, cb}, cq.pop_front());
		rd_d <= rd;
	end

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rreg(ADDR_CHAN_B_CONFIG_THIRD, 8'h0d);
		rreg(ADDR_AUX_A_HIGH, 8'h02);
		rreg(5'h1f, 8'h00);
		cmp({auxa, auxb, ga, gb}, {10'h200, 10'h200, 4'hd, 4'hd});
		// Each offset corner on A, its complement on B, with full-scale and random samples.
		foreach (tbl[i]) begin
			setofs(0, tbl[i], 4'h3);
			setofs(1, ~tbl[i], 4'hc);
			samp(14'h1fff, 14'h2000);
			samp(14'h2000, 14'h1fff);
			samp(14'h0000, 14'h0000);
			repeat (4) samp(14'($random(seed)), 14'($random(seed)));
			rreg(ADDR_CHAN_A_CONFIG_THIRD, {tbl[i][11:8], 4'h3});
		end
		// The full-scale corners have clamped both lanes by now; a write of one clears its own bit.
		rreg(ADDR_CLAMP_STATUS, 8'h03);
		put(1'b1, 1'b0, 1'b0, ADDR_CLAMP_STATUS, 8'h01);
		rreg(ADDR_CLAMP_STATUS, 8'h02);
		foreach (aux[i]) begin
			put(1'b1, 1'b0, 1'b0, ADDR_AUX_A_LOW, aux[i][7:0]);
			put(1'b1, 1'b0, 1'b0, ADDR_AUX_A_HIGH, {6'h00, aux[i][9:8]});
			put(1'b1, 1'b0, 1'b0, ADDR_AUX_B_LOW, ~aux[i][7:0]);
			put(1'b1, 1'b0, 1'b0, ADDR_AUX_B_HIGH, {6'h00, ~aux[i][9:8]});
			put(1'b0, 1'b0, 1'b0, addr, wdata);
			cmp({auxa, auxb, ga, gb}, {aux[i], ~aux[i], 4'h3, 4'hc});
		end
		repeat (3) put(1'b0, 1'b0, 1'b0, addr, wdata);
		cmp(cq.size() + rq.size(), 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
